// [src/radio_irq_pkg.sv]
// Purpose: Constants for the radio interrupt enable block
// Assumes: APB, 32-bit data, one word per register
// Notes: Field positions follow the enable register layout
package radio_irq_pkg;
  localparam int NUM_EVT = 12;
  localparam logic [11:0] OFS_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFS_ENABLE_CLEAR = 12'h308;
  localparam logic [11:0] OFS_EVT_STATUS = 12'h400;
  localparam logic [11:0] OFS_EVT_MASK = 12'h404;
  localparam logic [11:0] OFS_SAMPLE = 12'h548;
  localparam logic [11:0] OFS_BIT_COMPARE = 12'h560;
  localparam logic [11:0] OFS_BIT_COUNT = 12'h564;
  localparam int BIT_READY = 0;
  localparam int BIT_ADDRESS = 1;
  localparam int BIT_PAYLOAD = 2;
  localparam int BIT_END = 3;
  localparam int BIT_DISABLED = 4;
  localparam int BIT_DEV_HIT = 5;
  localparam int BIT_DEV_NO_HIT = 6;
  localparam int BIT_SS_DONE = 7;
  localparam int BIT_BC_HIT = 8;
  localparam int BIT_CK_GOOD = 10;
  localparam int BIT_CK_BAD = 11;
  // Field mask of implemented enables (bit 9 has no event)
  localparam logic [31:0] FIELD_MASK = 32'h00000dff;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam logic [7:0] SAMPLE_RESET = 8'h00;
endpackage : radio_irq_pkg

// [src/radio_sample_reg.sv]
// Purpose: Holds a signal strength sample and flags its arrival
// Assumes: Sample strobe is one cycle wide
// Notes: Done pulse rises with the sample load, so the readout is fresh
`timescale 1ns/100ps
module radio_sample_reg (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sample in
  input wire logic sample_valid,
  input wire logic [7:0] sample_in,
  // Readout and event
  output logic [7:0] sample,
  output logic done
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample <= radio_irq_pkg::SAMPLE_RESET;
    end else if (sample_valid) begin
      sample <= sample_in;
    end
  end

  // Event only once the readout holds the fresh value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0;
    end else begin
      done <= sample_valid;
    end
  end
endmodule : radio_sample_reg

// [src/radio_bit_compare.sv]
// Purpose: Bit counter compared against a software value
// Assumes: Counter restarts on each address event
// Notes: Hit pulses once when the count reaches the compare value
`timescale 1ns/100ps
module radio_bit_compare (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic restart,
  input wire logic bit_tick,
  input wire logic [31:0] compare,
  // Result
  output logic [31:0] count,
  output logic hit
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= radio_irq_pkg::RESET_WORD;
    end else if (restart) begin
      count <= radio_irq_pkg::RESET_WORD;
    end else if (bit_tick) begin
      count <= count + 32'h00000001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hit <= 1'b0;
    end else begin
      hit <= bit_tick && !restart && ((count + 32'h00000001) == compare);
    end
  end
endmodule : radio_bit_compare

// [src/radio_irq_enable_clear.sv]
// Purpose: Radio interrupt enables with set and clear registers
// Assumes: APB slave, zero wait states, events are one-cycle pulses
// Notes: Enable clear and enable set share one enable vector
// Notes on behaviour
// - Writing one clears ready enable; read shows it
// - Writing one clears address enable; read shows it
// - Writing one clears payload enable; read shows it
// - Writing one clears end enable; read shows it
// - Writing one clears disabled enable; read shows it
// - Writing one clears device hit enable
// - Writing one clears device no hit enable
// - Writing one clears strength done enable
// - Strength done fires on fresh sample
// - Writing one clears bit count hit enable
// - Bit count hit compares against compare register
// - Writing one clears checksum good enable
// - Writing one clears checksum bad enable
// - Set register sets enables; both read same
`timescale 1ns/100ps
module radio_irq_enable_clear (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Radio event pulses
  input wire logic EVT_READY,
  input wire logic EVT_ADDRESS,
  input wire logic EVT_PAYLOAD,
  input wire logic EVT_END,
  input wire logic EVT_DISABLED,
  input wire logic EVT_DEVICE_ADDRESS_HIT,
  input wire logic EVT_DEVICE_ADDRESS_NO_HIT,
  input wire logic EVT_CHECKSUM_GOOD,
  input wire logic EVT_CHECKSUM_BAD,
  // Signal strength sample and bit clock
  input wire logic SAMPLE_VALID,
  input wire logic [7:0] SAMPLE_IN,
  input wire logic BIT_TICK,
  // Interrupt
  output logic IRQ
);
  logic [31:0] enable;
  logic [31:0] status;
  logic [31:0] mask;
  logic [31:0] bit_count_compare_reg;
  logic [31:0] bit_count;
  logic [31:0] events;
  logic [31:0] next_read;
  logic [7:0] signal_strength_sample_reg;
  logic signal_strength_done;
  logic bit_count_hit;
  logic access;
  logic wr;
  logic hit_known;

  radio_sample_reg u_sample (
    .clk(CLK),
    .resetn(RESETN),
    .sample_valid(SAMPLE_VALID),
    .sample_in(SAMPLE_IN),
    .sample(signal_strength_sample_reg),
    .done(signal_strength_done)
  );

  radio_bit_compare u_bits (
    .clk(CLK),
    .resetn(RESETN),
    .restart(EVT_ADDRESS),
    .bit_tick(BIT_TICK),
    .compare(bit_count_compare_reg),
    .count(bit_count),
    .hit(bit_count_hit)
  );

  // Zero wait states; every access completes in its access phase
  assign PREADY = 1'b1;
  assign access = PSEL && PENABLE;
  assign wr = access && PWRITE;

  always_comb begin
    hit_known = 1'b1;
    unique case (PADDR)
      radio_irq_pkg::OFS_ENABLE_SET,
      radio_irq_pkg::OFS_ENABLE_CLEAR,
      radio_irq_pkg::OFS_EVT_STATUS,
      radio_irq_pkg::OFS_EVT_MASK,
      radio_irq_pkg::OFS_SAMPLE,
      radio_irq_pkg::OFS_BIT_COMPARE,
      radio_irq_pkg::OFS_BIT_COUNT: hit_known = 1'b1;
      default: hit_known = 1'b0;
    endcase
  end

  // Unmapped addresses answer with an error, reads give zero
  assign PSLVERR = access && !hit_known;

  always_comb begin
    events = radio_irq_pkg::RESET_WORD;
    events[radio_irq_pkg::BIT_READY] = EVT_READY;
    events[radio_irq_pkg::BIT_ADDRESS] = EVT_ADDRESS;
    events[radio_irq_pkg::BIT_PAYLOAD] = EVT_PAYLOAD;
    events[radio_irq_pkg::BIT_END] = EVT_END;
    events[radio_irq_pkg::BIT_DISABLED] = EVT_DISABLED;
    events[radio_irq_pkg::BIT_DEV_HIT] = EVT_DEVICE_ADDRESS_HIT;
    events[radio_irq_pkg::BIT_DEV_NO_HIT] = EVT_DEVICE_ADDRESS_NO_HIT;
    events[radio_irq_pkg::BIT_SS_DONE] = signal_strength_done;
    events[radio_irq_pkg::BIT_BC_HIT] = bit_count_hit;
    events[radio_irq_pkg::BIT_CK_GOOD] = EVT_CHECKSUM_GOOD;
    events[radio_irq_pkg::BIT_CK_BAD] = EVT_CHECKSUM_BAD;
  end

  // One enable bit per field; zero bits of a write leave it alone
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_en
      always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
          enable[i] <= 1'b0;
        end else if (radio_irq_pkg::FIELD_MASK[i] && wr && PWDATA[i]) begin
          // Set register sets, clear register clears
          if (PADDR == radio_irq_pkg::OFS_ENABLE_SET) begin
            enable[i] <= 1'b1;
          end else if (PADDR == radio_irq_pkg::OFS_ENABLE_CLEAR) begin
            enable[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Sticky flags: a new event wins over a same-cycle clear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      status <= radio_irq_pkg::RESET_WORD;
    end else if (wr && PADDR == radio_irq_pkg::OFS_EVT_STATUS) begin
      status <= ((status & ~PWDATA) | events) & radio_irq_pkg::FIELD_MASK;
    end else begin
      status <= (status | events) & radio_irq_pkg::FIELD_MASK;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mask <= radio_irq_pkg::RESET_WORD;
    end else if (wr && PADDR == radio_irq_pkg::OFS_EVT_MASK) begin
      mask <= PWDATA & radio_irq_pkg::FIELD_MASK;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bit_count_compare_reg <= radio_irq_pkg::RESET_WORD;
    end else if (wr && PADDR == radio_irq_pkg::OFS_BIT_COMPARE) begin
      bit_count_compare_reg <= PWDATA;
    end
  end

  // Interrupt needs a flag, its enable and its mask bit
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status & enable & mask);
    end
  end

  always_comb begin
    next_read = radio_irq_pkg::RESET_WORD;
    unique case (PADDR)
      radio_irq_pkg::OFS_ENABLE_SET: next_read = enable;
      radio_irq_pkg::OFS_ENABLE_CLEAR: next_read = enable;
      radio_irq_pkg::OFS_EVT_STATUS: next_read = status;
      radio_irq_pkg::OFS_EVT_MASK: next_read = mask;
      radio_irq_pkg::OFS_SAMPLE: next_read = {24'h000000, signal_strength_sample_reg};
      radio_irq_pkg::OFS_BIT_COMPARE: next_read = bit_count_compare_reg;
      radio_irq_pkg::OFS_BIT_COUNT: next_read = bit_count;
      default: next_read = radio_irq_pkg::RESET_WORD;
    endcase
  end

  // Read data registered in the setup cycle, valid in the access phase
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= radio_irq_pkg::RESET_WORD;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= next_read;
    end
  end
endmodule : radio_irq_enable_clear

// [verif/radio_irq_assertions.sv]
// Purpose: Assertions on the bus and interrupt ports
// Assumes: Zero-wait slave, read data loaded at setup
// Notes: Bound to every instance of the block
`timescale 1ns/100ps
module radio_irq_checker (
  // Watched ports
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic acc;
  logic hit;
  assign acc = PSEL && PENABLE;
  assign hit = PADDR inside {12'h304, 12'h308, 12'h400, 12'h404, 12'h548, 12'h560, 12'h564};
  sequence clr_all_s;
    acc && PWRITE && PADDR == 12'h308 && PWDATA == radio_irq_pkg::FIELD_MASK;
  endsequence
  sequence en_rd_s;
    PSEL && !PENABLE && !PWRITE && PADDR[11:4] == 8'h30;
  endsequence
  ready_tied_a: assert property (PREADY) else $error("ready low");
  bad_addr_a: assert property (acc && !hit |-> PSLVERR) else $error("no error");
  good_addr_a: assert property (acc && hit |-> !PSLVERR) else $error("false error");
  bad_read_a: assert property (acc && !PWRITE && !hit |-> PRDATA == 32'h0)
    else $error("unmapped data");
  spare_bits_a: assert property (acc && !PWRITE && PADDR[11:8] inside {4'h3, 4'h4}
    |-> (PRDATA & ~radio_irq_pkg::FIELD_MASK) == 32'h0) else $error("spare bits");
  clr_irq_a: assert property (clr_all_s |-> ##2 !IRQ) else $error("irq stays");
  mask_irq_a: assert property (acc && PWRITE && PADDR == 12'h404 && PWDATA == 32'h0
    |-> ##2 !IRQ) else $error("masked irq");
  clr_read_a: assert property (clr_all_s ##1 en_rd_s |=> PRDATA == 32'h0)
    else $error("enable left");
  reset_irq_a: assert property ($rose(RESETN) |-> !IRQ) else $error("irq at reset");
endmodule : radio_irq_checker
bind radio_irq_enable_clear radio_irq_checker chk_i (.CLK, .RESETN, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IRQ);

// [verif/radio_irq_enable_clear_tb_top.sv]
// Purpose: Self-checking bench for the radio interrupt enables
// Assumes: Zero-wait bus, one-cycle event pulses
// Notes: Every task starts just after a clock edge
`timescale 1ns/100ps
module radio_irq_enable_clear_tb_top;
  localparam logic [31:0] fm = radio_irq_pkg::FIELD_MASK;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sv = 1'b0, tick = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [8:0] evt = 9'h000;
  logic [7:0] sin = 8'h00;
  logic pready, pslverr, irq, err;
  int error_cnt = 0, check_count = 0;
  always #4 clk = ~clk;
  radio_irq_enable_clear uut (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EVT_READY(evt[0]), .EVT_ADDRESS(evt[1]), .EVT_PAYLOAD(evt[2]),
    .EVT_END(evt[3]), .EVT_DISABLED(evt[4]), .EVT_DEVICE_ADDRESS_HIT(evt[5]),
    .EVT_DEVICE_ADDRESS_NO_HIT(evt[6]), .EVT_CHECKSUM_GOOD(evt[7]),
    .EVT_CHECKSUM_BAD(evt[8]), .SAMPLE_VALID(sv), .SAMPLE_IN(sin), .BIT_TICK(tick),
    .IRQ(irq));
  task automatic summarize;
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Leaves psel high so a transfer may follow back to back
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
  endtask : bus
  task automatic idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic t_reset;
    bus(1'b0, 12'h304, 0);
    chk("set reset", 32'h0, rd);
    bus(1'b0, 12'h308, 0);
    chk("clear reset", 32'h0, rd);
    bus(1'b0, 12'h404, 0);
    chk("mask reset", 32'h0, rd);
    bus(1'b1, 12'h304, 32'hffffffff);
    bus(1'b0, 12'h304, 0);
    chk("spare bits", fm, rd);
    bus(1'b0, 12'h010, 0);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, err});
    idle(1);
  endtask : t_reset
  task automatic t_clear;
    for (int k = 0; k < 12; k++) begin
      if (k == 9) continue;
      bus(1'b1, 12'h304, fm);
      bus(1'b1, 12'h308, 32'h1 << k);
      bus(1'b1, 12'h308, 32'h0);
      bus(1'b0, 12'h308, 0);
      chk("clear field", fm & ~(32'h1 << k), rd);
      bus(1'b0, 12'h304, 0);
      chk("set view", fm & ~(32'h1 << k), rd);
    end
    bus(1'b1, 12'h308, fm);
    bus(1'b0, 12'h308, 0);
    chk("clear all", 32'h0, rd);
    idle(1);
  endtask : t_clear
  task automatic t_irq;
    int pos [9] = '{0, 1, 2, 3, 4, 5, 6, 10, 11};
    bus(1'b1, 12'h404, fm);
    bus(1'b1, 12'h304, fm);
    foreach (pos[i]) begin
      idle(1);
      evt[i] <= 1'b1;
      @(posedge clk);
      evt[i] <= 1'b0;
      idle(2);
      chk("irq on event", 32'h1, {31'h0, irq});
      bus(1'b0, 12'h400, 0);
      chk("status", 32'h1 << pos[i], rd);
      bus(1'b1, 12'h400, rd);
      idle(2);
      chk("irq after ack", 32'h0, {31'h0, irq});
    end
    evt[3] <= 1'b1;
    @(posedge clk);
    evt[3] <= 1'b0;
    bus(1'b1, 12'h308, 32'h8);
    idle(2);
    chk("irq disabled", 32'h0, {31'h0, irq});
    bus(1'b1, 12'h304, 32'h8);
    idle(2);
    chk("irq enabled", 32'h1, {31'h0, irq});
    bus(1'b1, 12'h404, 32'h0);
    idle(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, 12'h400, fm);
  endtask : t_irq
  task automatic t_sample;
    bus(1'b1, 12'h404, fm);
    psel <= 1'b0;
    sv <= 1'b1;
    sin <= 8'ha5;
    @(posedge clk);
    sv <= 1'b0;
    idle(3);
    chk("irq on sample", 32'h1, {31'h0, irq});
    bus(1'b0, 12'h548, 0);
    chk("sample", 32'ha5, rd);
    bus(1'b0, 12'h400, 0);
    chk("sample done", 32'h80, rd);
    bus(1'b1, 12'h400, fm);
  endtask : t_sample
  task automatic t_bits;
    bus(1'b1, 12'h560, 32'h3);
    psel <= 1'b0;
    evt[1] <= 1'b1;
    @(posedge clk);
    evt[1] <= 1'b0;
    for (int t = 1; t <= 3; t++) begin
      idle(1);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      idle(3);
      bus(1'b0, 12'h400, 0);
      chk("count hit", t == 3 ? 32'h102 : 32'h2, rd);
    end
    bus(1'b0, 12'h564, 0);
    chk("bit count", 32'h3, rd);
    idle(1);
  endtask : t_bits
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_clear();
    t_irq();
    t_sample();
    t_bits();
    summarize();
  end
endmodule : radio_irq_enable_clear_tb_top
